// file: ppc_cfg.svh
// constants for the pedestrian call channel control block
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH

`define PPC_CHANNELS       4
`define PPC_OVR_INPUTS     2
`define PPC_IN_W           18
`define PPC_CNT_W          13

// timing base
`define PPC_CLK_PERIOD_NS  20
`define PPC_TICK_PERIOD_NS 1000000
`define PPC_NS_PER_MS      1000000
`define PPC_TICK_CYCLES    (`PPC_TICK_PERIOD_NS / `PPC_CLK_PERIOD_NS)

// times in milliseconds and their tick counts
`define PPC_DEBOUNCE_MS    20
`define PPC_LOCK_MS        2000
`define PPC_HOLD_MS        5000
`define PPC_FLASH_MS       1000
`define PPC_BLINK_MS       200
`define PPC_CLEAR_MS       500
`define PPC_BRIEF_MS       500
`define PPC_MS_TICKS(ms)   ((ms) * `PPC_NS_PER_MS / `PPC_TICK_PERIOD_NS)

// register map
`define PPC_CTRL_ADDR      8'h00
`define PPC_STATUS_ADDR    8'h04
`define PPC_ADDR_LSB_W     8
`define PPC_CTRL_RESET     3'h0

// status word fields
`define PPC_ST_CALL_LSB    0
`define PPC_ST_LOCK_LSB    4
`define PPC_ST_POWER_LSB   8
`define PPC_ST_FLASH_LSB   12
`define PPC_ST_OVR_BIT     16

`endif

// file: ppc_pkg.sv
// shared types for the pedestrian call channel control block
`include "ppc_cfg.svh"
package ppc_pkg;

   typedef enum logic [2:0] {
      P_IDLE,
      P_SHORT,
      P_LOCKING,
      P_LOCKED,
      P_UNLOCKING
   } ppc_panel_state_type;

   typedef struct packed {
      logic status_compat;
      logic walk_option;
      logic latch_mode;
   } ppc_ctrl_type;

   typedef struct packed {
      logic [`PPC_OVR_INPUTS-1:0] override_n;
      logic [`PPC_CHANNELS-1:0]   dont_walk;
      logic [`PPC_CHANNELS-1:0]   walk;
      logic [`PPC_CHANNELS-1:0]   panel;
      logic [`PPC_CHANNELS-1:0]   field;
   } ppc_inputs_type;

endpackage

// file: ppc_debounce.sv
// two-flop synchroniser and per-bit debounce filter
`timescale 1ns/1ns
`include "ppc_cfg.svh"
module ppc_debounce
   import ppc_pkg::*;
#(
   parameter logic [`PPC_IN_W-1:0] INIT = '0
)
(
   // clock and reset
   input  wire logic                 i_sys_clk,
   input  wire logic                 i_resetn,
   input  wire logic                 i_tick,
   // raw and filtered levels
   input  wire logic [`PPC_IN_W-1:0] i_raw,
   output logic      [`PPC_IN_W-1:0] o_clean
);

   logic [`PPC_IN_W-1:0] meta_q;
   logic [`PPC_IN_W-1:0] sync_q;

   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         meta_q <= INIT;
         sync_q <= INIT;
      end
      else
      begin
         meta_q <= i_raw;
         sync_q <= meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // level must stand a full debounce time before it is taken
   genvar gi;
   generate
      for (gi = 0; gi < `PPC_IN_W; gi++)
      begin : g_bit
         logic [4:0] cnt_q;
         always_ff @(posedge i_sys_clk or negedge i_resetn)
         begin
            if (!i_resetn)
            begin
               cnt_q         <= 5'h00;
               o_clean[gi]   <= INIT[gi];
            end
            else if (sync_q[gi] == o_clean[gi])
               cnt_q <= 5'h00;
            else if (i_tick)
            begin
               if (cnt_q == 5'(`PPC_MS_TICKS(`PPC_DEBOUNCE_MS) - 1))
               begin
                  cnt_q       <= 5'h00;
                  o_clean[gi] <= sync_q[gi];
               end
               else
                  cnt_q <= cnt_q + 5'h01;
            end
         end
      end
   endgenerate

endmodule // ppc_debounce

// file: ppc_channel_ctrl.sv
// four-channel pedestrian call control with an AHB-Lite register slave
`timescale 1ns/1ns
`include "ppc_cfg.svh"
module ppc_channel_ctrl
   import ppc_pkg::*;
#(
   parameter int TICK_CYCLES = `PPC_TICK_CYCLES,
   parameter int HOLD_TICKS  = `PPC_MS_TICKS(`PPC_HOLD_MS)
)
(
   // clock and reset
   input  wire logic                       i_sys_clk,
   input  wire logic                       i_resetn,
   // ahb-lite slave
   input  wire logic                       i_hsel,
   input  wire logic [31:0]                i_haddr,
   input  wire logic [1:0]                 i_htrans,
   input  wire logic                       i_hwrite,
   input  wire logic [2:0]                 i_hsize,
   input  wire logic [31:0]                i_hwdata,
   input  wire logic                       i_hready,
   output logic      [31:0]                o_hrdata,
   output logic                            o_hreadyout,
   output logic                            o_hresp,
   // cabinet pins
   input  wire logic [`PPC_CHANNELS-1:0]   i_field_request_button,
   input  wire logic [`PPC_CHANNELS-1:0]   i_panel_button,
   input  wire logic [`PPC_CHANNELS-1:0]   i_walk,
   input  wire logic [`PPC_CHANNELS-1:0]   i_dont_walk,
   input  wire logic [`PPC_OVR_INPUTS-1:0] i_override_n,
   // channel outputs
   output logic      [`PPC_CHANNELS-1:0]   o_pedestrian_call_request,
   output logic      [`PPC_CHANNELS-1:0]   o_led,
   output logic      [`PPC_CHANNELS-1:0]   o_field_power,
   output logic      [`PPC_CHANNELS-1:0]   o_status
);

   ////////////////////////////////////////////////////////////////////////////
   // millisecond tick
   logic [15:0]         tick_cnt_q;
   logic                tick_q;

   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         tick_cnt_q <= 16'h0000;
         tick_q     <= 1'b0;
      end
      else if (tick_cnt_q == 16'(TICK_CYCLES - 1))
      begin
         tick_cnt_q <= 16'h0000;
         tick_q     <= 1'b1;
      end
      else
      begin
         tick_cnt_q <= tick_cnt_q + 16'h0001;
         tick_q     <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // input conditioning
   ppc_inputs_type      raw;
   ppc_inputs_type      din;
   logic [`PPC_IN_W-1:0] clean;

   assign raw.field      = i_field_request_button;
   assign raw.panel      = i_panel_button;
   assign raw.walk       = i_walk;
   assign raw.dont_walk  = i_dont_walk;
   assign raw.override_n = i_override_n;
   assign din            = ppc_inputs_type'(clean);

   // override pins idle high, so they start inactive
   ppc_debounce #(
      .INIT  ({{`PPC_OVR_INPUTS{1'b1}}, {(`PPC_IN_W - `PPC_OVR_INPUTS){1'b0}}})
   ) u_debounce (
      .i_sys_clk (i_sys_clk),
      .i_resetn  (i_resetn),
      .i_tick    (tick_q),
      .i_raw     (raw),
      .o_clean   (clean)
   );

   logic                override_act;
   assign override_act = ~&din.override_n; // either input low

   ////////////////////////////////////////////////////////////////////////////
   // ahb-lite slave, zero wait states
   ppc_ctrl_type        ctrl_q;
   logic                wr_pend_q;
   logic [`PPC_ADDR_LSB_W-1:0] wr_addr_q;
   logic [31:0]         status_word;
   logic                addr_phase;

   assign addr_phase = i_hsel & i_htrans[1] & i_hready;

   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= '0;
         o_hrdata  <= 32'h00000000;
      end
      else
      begin
         wr_pend_q <= addr_phase & i_hwrite;
         if (addr_phase)
            wr_addr_q <= i_haddr[`PPC_ADDR_LSB_W-1:0];
         if (addr_phase && !i_hwrite)
         begin
            if (i_haddr[`PPC_ADDR_LSB_W-1:0] == `PPC_CTRL_ADDR)
               o_hrdata <= {29'h00000000, ctrl_q};
            else if (i_haddr[`PPC_ADDR_LSB_W-1:0] == `PPC_STATUS_ADDR)
               o_hrdata <= status_word;
            else
               o_hrdata <= 32'h00000000;
         end
      end
   end

   // switch settings live in the control word
   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         ctrl_q <= `PPC_CTRL_RESET;
      else if (wr_pend_q && wr_addr_q == `PPC_CTRL_ADDR)
         ctrl_q <= ppc_ctrl_type'(i_hwdata[2:0]);
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
      end
      else
      begin
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-channel logic
   logic [`PPC_CHANNELS-1:0] call_d;
   logic [`PPC_CHANNELS-1:0] led_d;
   logic [`PPC_CHANNELS-1:0] power_d;
   logic [`PPC_CHANNELS-1:0] locked;
   logic [`PPC_CHANNELS-1:0] flash;

   genvar ch;
   generate
      for (ch = 0; ch < `PPC_CHANNELS; ch++)
      begin : g_chan
         ppc_panel_state_type     panel_q;
         logic                    panel_prev_q;
         logic                    walk_prev_q;
         logic [`PPC_CNT_W-1:0]   hold_cnt_q;
         logic [`PPC_CNT_W-1:0]   blink_cnt_q;
         logic [`PPC_CNT_W-1:0]   clear_cnt_q;
         logic [`PPC_CNT_W-1:0]   flash_cnt_q;
         logic                    flash_q;
         logic [`PPC_CNT_W-1:0]   walk_hold_q;
         logic                    pend_q;
         logic [`PPC_CNT_W-1:0]   brief_cnt_q;
         logic                    panel_rise;
         logic                    walk_rise;
         logic                    walk_fall;
         logic                    power_off;
         logic                    panel_call;
         logic                    field_call;

         assign panel_rise = din.panel[ch] & ~panel_prev_q;
         assign walk_rise  = din.walk[ch] & ~walk_prev_q;
         assign walk_fall  = ~din.walk[ch] & walk_prev_q;

         always_ff @(posedge i_sys_clk or negedge i_resetn)
         begin
            if (!i_resetn)
            begin
               panel_prev_q <= 1'b0;
               walk_prev_q  <= 1'b0;
            end
            else
            begin
               panel_prev_q <= din.panel[ch];
               walk_prev_q  <= din.walk[ch];
            end
         end

         // front-panel button: short, lock and release
         always_ff @(posedge i_sys_clk or negedge i_resetn)
         begin
            if (!i_resetn)
            begin
               panel_q    <= P_IDLE;
               hold_cnt_q <= '0;
            end
            else if (override_act)
               panel_q <= P_IDLE;
            else
            begin
               case (panel_q)
                  P_IDLE:
                  begin
                     hold_cnt_q <= '0;
                     if (panel_rise)
                        panel_q <= P_SHORT;
                  end
                  P_SHORT:
                  begin
                     if (!din.panel[ch])
                        panel_q <= P_IDLE;
                     else if (tick_q)
                     begin
                        if (hold_cnt_q == `PPC_CNT_W'(`PPC_MS_TICKS(`PPC_LOCK_MS) - 1))
                           panel_q <= P_LOCKING;
                        else
                           hold_cnt_q <= hold_cnt_q + 1'b1;
                     end
                  end
                  P_LOCKING:
                     if (!din.panel[ch])
                        panel_q <= P_LOCKED;
                  P_LOCKED:
                     if (panel_rise)
                        panel_q <= P_UNLOCKING;
                  P_UNLOCKING:
                     // waits out the press so a long one does not relock
                     if (!din.panel[ch])
                        panel_q <= P_IDLE;
                  default:
                     panel_q <= P_IDLE;
               endcase
            end
         end

         // led blink marks the lock point
         always_ff @(posedge i_sys_clk or negedge i_resetn)
         begin
            if (!i_resetn)
               blink_cnt_q <= '0;
            else if (panel_q == P_SHORT && tick_q &&
                     hold_cnt_q == `PPC_CNT_W'(`PPC_MS_TICKS(`PPC_LOCK_MS) - 1))
               blink_cnt_q <= `PPC_CNT_W'(`PPC_MS_TICKS(`PPC_BLINK_MS));
            else if (tick_q && blink_cnt_q != '0)
               blink_cnt_q <= blink_cnt_q - 1'b1;
         end

         // brief power cut on walk start clears latched button leds
         always_ff @(posedge i_sys_clk or negedge i_resetn)
         begin
            if (!i_resetn)
               clear_cnt_q <= '0;
            else if (walk_rise && ctrl_q.latch_mode && ctrl_q.walk_option)
               clear_cnt_q <= `PPC_CNT_W'(`PPC_MS_TICKS(`PPC_CLEAR_MS));
            else if (tick_q && clear_cnt_q != '0)
               clear_cnt_q <= clear_cnt_q - 1'b1;
         end

         // flash: both lamps dark long enough, still inside 2 s
         always_ff @(posedge i_sys_clk or negedge i_resetn)
         begin
            if (!i_resetn)
            begin
               flash_cnt_q <= '0;
               flash_q     <= 1'b0;
            end
            else if (din.walk[ch] || din.dont_walk[ch])
            begin
               flash_cnt_q <= '0;
               flash_q     <= 1'b0;
            end
            else if (tick_q && !flash_q)
            begin
               if (flash_cnt_q == `PPC_CNT_W'(`PPC_MS_TICKS(`PPC_FLASH_MS) - 1))
                  flash_q <= 1'b1;
               else
                  flash_cnt_q <= flash_cnt_q + 1'b1;
            end
         end

         // long field press during walk gives a brief call after walk
         always_ff @(posedge i_sys_clk or negedge i_resetn)
         begin
            if (!i_resetn)
            begin
               walk_hold_q <= '0;
               pend_q      <= 1'b0;
               brief_cnt_q <= '0;
            end
            else
            begin
               if (!(din.walk[ch] && ctrl_q.walk_option && din.field[ch]))
                  walk_hold_q <= '0;
               else if (tick_q && !pend_q)
               begin
                  if (walk_hold_q == `PPC_CNT_W'(HOLD_TICKS - 1))
                     pend_q <= 1'b1;
                  else
                     walk_hold_q <= walk_hold_q + 1'b1;
               end
               if (walk_fall && pend_q)
               begin
                  pend_q      <= 1'b0;
                  brief_cnt_q <= `PPC_CNT_W'(`PPC_MS_TICKS(`PPC_BRIEF_MS));
               end
               else if (tick_q && brief_cnt_q != '0)
                  brief_cnt_q <= brief_cnt_q - 1'b1;
            end
         end

         // walk with option off keeps buttons dead for the whole walk
         assign power_off = override_act
                          | flash_q
                          | (din.walk[ch] & ~ctrl_q.walk_option)
                          | (clear_cnt_q != '0);
         assign panel_call = (panel_q == P_SHORT) | (panel_q == P_LOCKING)
                           | (panel_q == P_LOCKED);
         assign field_call = din.field[ch] & ~power_off;
         assign call_d[ch] = field_call | panel_call | override_act
                           | (brief_cnt_q != '0);
         // fail-safe calls are part of call_d, so they light leds like any other call
         assign led_d[ch]   = call_d[ch] & (blink_cnt_q == '0);
         assign power_d[ch] = ~power_off;
         assign locked[ch]  = (panel_q == P_LOCKING) | (panel_q == P_LOCKED);
         assign flash[ch]   = flash_q;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // registered outputs, one cycle behind the channel logic
   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_pedestrian_call_request <= '0;
         o_led                     <= '0;
         o_field_power             <= '0;
         o_status                  <= '0;
      end
      else
      begin
         o_pedestrian_call_request <= call_d;
         o_led                     <= led_d;
         o_field_power             <= power_d;
         o_status                  <= {`PPC_CHANNELS{ctrl_q.status_compat}};
      end
   end

   always_comb
   begin
      status_word                                       = 32'h00000000;
      status_word[`PPC_ST_CALL_LSB +: `PPC_CHANNELS]    = o_pedestrian_call_request;
      status_word[`PPC_ST_LOCK_LSB +: `PPC_CHANNELS]    = locked;
      status_word[`PPC_ST_POWER_LSB +: `PPC_CHANNELS]   = o_field_power;
      status_word[`PPC_ST_FLASH_LSB +: `PPC_CHANNELS]   = flash;
      status_word[`PPC_ST_OVR_BIT]                      = override_act;
   end

endmodule // ppc_channel_ctrl

// file: ppc_channel_ctrl_assertions.sv
// port-level checks for the pedestrian call channel control block
`timescale 1ns/1ns
`include "ppc_cfg.svh"
module ppc_channel_ctrl_assertions
#(
   parameter int TICK_CYCLES = 10
)
(
   // clock, reset and bus
   input wire logic                       i_sys_clk,
   input wire logic                       i_resetn,
   input wire logic                       i_hsel,
   input wire logic [31:0]                i_haddr,
   input wire logic [1:0]                 i_htrans,
   input wire logic                       i_hwrite,
   input wire logic [31:0]                i_hwdata,
   input wire logic                       i_hready,
   input wire logic [31:0]                o_hrdata,
   input wire logic                       o_hreadyout,
   input wire logic                       o_hresp,
   // cabinet pins
   input wire logic [`PPC_CHANNELS-1:0]   i_walk,
   input wire logic [`PPC_CHANNELS-1:0]   i_dont_walk,
   input wire logic [`PPC_OVR_INPUTS-1:0] i_override_n,
   // channel outputs
   input wire logic [`PPC_CHANNELS-1:0]   o_pedestrian_call_request,
   input wire logic [`PPC_CHANNELS-1:0]   o_led,
   input wire logic [`PPC_CHANNELS-1:0]   o_field_power,
   input wire logic [`PPC_CHANNELS-1:0]   o_status
);
   // 2 s response limit less one cycle, so a slow design still trips
   localparam int RESP_LIM = 2000 * TICK_CYCLES - 1;
   localparam int WALK_LIM = 50 * TICK_CYCLES;
   logic       taken;
   logic       wr_ctrl_q;
   logic [2:0] ctrl_q;
   int         ovr_cnt_q;
   int         flash_cnt_q;
   int         walk_cnt_q;
   assign taken = i_hsel & i_htrans[1] & i_hready;
   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         wr_ctrl_q <= 1'b0;
         ctrl_q <= 3'h0;
      end
      else
      begin
         wr_ctrl_q <= taken & i_hwrite & (i_haddr[7:0] == 8'h00);
         if (wr_ctrl_q)
            ctrl_q <= i_hwdata[2:0];
      end
   end
   // saturating counters, so the checks keep firing while a condition lasts
   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         ovr_cnt_q <= 0;
         flash_cnt_q <= 0;
         walk_cnt_q <= 0;
      end
      else
      begin
         ovr_cnt_q <= (&i_override_n) ? 0 : ovr_cnt_q + int'(ovr_cnt_q < RESP_LIM);
         flash_cnt_q <= (i_walk[1] | i_dont_walk[1]) ? 0 :
                        flash_cnt_q + int'(flash_cnt_q < RESP_LIM);
         walk_cnt_q <= (i_walk[3] & ~ctrl_q[1]) ? walk_cnt_q + int'(walk_cnt_q < WALK_LIM) : 0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking dc @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);
   sequence rd_unmapped;
      taken & !i_hwrite & (i_haddr[7:0] != 8'h00) & (i_haddr[7:0] != 8'h04);
   endsequence
   sequence rd_status;
      taken & !i_hwrite & (i_haddr[7:0] == 8'h04);
   endsequence
   sequence ctrl_settled;
      $stable(ctrl_q) [*4];
   endsequence
   bus_okay_a: assert property (o_hresp == 1'b0 && o_hreadyout == 1'b1)
      else $error("bus response not okay or not ready");
   unmapped_zero_a: assert property (rd_unmapped |=> o_hrdata == 32'h0)
      else $error("unmapped read not zero");
   status_reserved_a: assert property (rd_status |=> o_hrdata[31:17] == 15'h0)
      else $error("status reserved bits set");
   led_call_a: assert property ((o_led & ~o_pedestrian_call_request) == 4'h0)
      else $error("led lit without call");
   status_follow_a: assert property (ctrl_settled |-> o_status == {4{ctrl_q[2]}})
      else $error("status outputs not following switch");
   override_all_a: assert property (ovr_cnt_q == RESP_LIM |->
      o_pedestrian_call_request == 4'hF && o_field_power == 4'h0)
      else $error("override not answered in time");
   flash_power_a: assert property (flash_cnt_q == RESP_LIM |-> !o_field_power[1])
      else $error("flash did not remove power");
   walk_power_a: assert property (walk_cnt_q == WALK_LIM |-> !o_field_power[3])
      else $error("power kept on during walk");
   power_gate_a: assert property ($rose(o_field_power[0]) |-> &i_override_n)
      else $error("power restored under override");
endmodule // ppc_channel_ctrl_assertions

bind ppc_channel_ctrl ppc_channel_ctrl_assertions #(.TICK_CYCLES(TICK_CYCLES)) chk
(
   .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_hsel(i_hsel), .i_haddr(i_haddr),
   .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
   .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_walk(i_walk),
   .i_dont_walk(i_dont_walk), .i_override_n(i_override_n), .o_led(o_led),
   .o_pedestrian_call_request(o_pedestrian_call_request),
   .o_field_power(o_field_power), .o_status(o_status)
);

// file: ppc_cabinet_model.sv
// load switch and field button model for the cabinet side
`timescale 1ns/1ns
`include "ppc_cfg.svh"
module ppc_cabinet_model
(
   // commands from the bench
   input  wire logic [`PPC_CHANNELS-1:0] i_walk_cmd,
   input  wire logic [`PPC_CHANNELS-1:0] i_flash_cmd,
   input  wire logic [`PPC_CHANNELS-1:0] i_press_cmd,
   // cabinet pins
   output logic      [`PPC_CHANNELS-1:0] o_walk,
   output logic      [`PPC_CHANNELS-1:0] o_dont_walk,
   output logic      [`PPC_CHANNELS-1:0] o_field_request_button
);
   // one lamp lit per channel, both dark while the controller flashes
   assign o_walk = i_walk_cmd & ~i_flash_cmd;
   assign o_dont_walk = ~i_walk_cmd & ~i_flash_cmd;
   // contact closes whether or not the button is powered
   assign o_field_request_button = i_press_cmd;
endmodule // ppc_cabinet_model

// file: testbench.sv
// self-checking bench for the pedestrian call channel control block
`timescale 1ns/1ns
`include "ppc_cfg.svh"
module testbench;
   localparam int TC = 2;
   logic        i_sys_clk;
   logic        i_resetn;
   logic        i_hsel;
   logic [31:0] i_haddr;
   logic [1:0]  i_htrans;
   logic        i_hwrite;
   logic [31:0] i_hwdata;
   logic [31:0] o_hrdata;
   logic        o_hreadyout;
   logic        o_hresp;
   logic [1:0]  ovr_n;
   logic [3:0]  panel, walk_cmd, flash_cmd, press_cmd, walk, dont_walk, field;
   logic [3:0]  call, led, power, status;
   int          n_mismatch;
   int          num_checks;
   ppc_channel_ctrl #(.TICK_CYCLES(TC)) uut
   (
      .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_hsel(i_hsel), .i_haddr(i_haddr),
      .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata),
      .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
      .o_hresp(o_hresp), .i_field_request_button(field), .i_panel_button(panel),
      .i_walk(walk), .i_dont_walk(dont_walk), .i_override_n(ovr_n),
      .o_pedestrian_call_request(call), .o_led(led), .o_field_power(power),
      .o_status(status)
   );
   ppc_cabinet_model model
   (
      .i_walk_cmd(walk_cmd), .i_flash_cmd(flash_cmd), .i_press_cmd(press_cmd),
      .o_walk(walk), .o_dont_walk(dont_walk), .o_field_request_button(field)
   );
   initial
   begin
      i_sys_clk = 1'b0;
      forever #10 i_sys_clk = ~i_sys_clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic results();
      if (n_mismatch == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_ms(input int n);
      repeat (n * TC) @(posedge i_sys_clk);
   endtask
   // bounded so a stuck slave ends the run instead of hanging it
   task automatic wait_ready();
      int n;
      n = 0;
      do
      begin
         @(posedge i_sys_clk);
         n++;
      end
      while (o_hreadyout !== 1'b1 && n < 100);
      if (o_hreadyout !== 1'b1)
      begin
         n_mismatch++;
         $display("Error at %0t: bus timeout", $time);
         results();
      end
   endtask
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      i_hsel <= 1'b1;
      i_htrans <= 2'b10;
      i_haddr <= a;
      i_hwrite <= wr;
      wait_ready();
      i_hsel <= 1'b0;
      i_htrans <= 2'b00;
      i_hwdata <= wd;
      wait_ready();
      rd = o_hrdata;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      logic [31:0] r;
      check(power, 4'hF);
      ahb(1'b0, 32'h0, 32'h0, r);
      check(r, 32'h0);
      ahb(1'b1, 32'h0, 32'h7, r);
      ahb(1'b0, 32'h0, 32'h0, r);
      check(r, 32'h7);
      ahb(1'b0, 32'h8, 32'h0, r);
      check(r, 32'h0);
      wait_ms(1);
      check(status, 4'hF);
      ahb(1'b1, 32'h0, 32'h1, r);
      wait_ms(1);
      check(status, 4'h0);
   endtask
   task automatic t_lock(input int ch);
      logic [31:0] r;
      panel[ch] <= 1'b1;
      wait_ms(2100);
      check(led[ch], 1'b0);
      wait_ms(400);
      panel[ch] <= 1'b0;
      wait_ms(100);
      check(call[ch], 1'b1);
      ahb(1'b0, 32'h4, 32'h0, r);
      check(r, 32'h00000F00 | (32'h11 << ch));
   endtask
   task automatic t_panel();
      panel[1] <= 1'b1;
      wait_ms(100);
      check(call, 4'h2);
      check(led, 4'h2);
      panel[1] <= 1'b0;
      wait_ms(50);
      check(call, 4'h0);
      t_lock(2);
      panel[2] <= 1'b1;
      wait_ms(100);
      panel[2] <= 1'b0;
      wait_ms(100);
      check(call, 4'h0);
   endtask
   task automatic t_walk();
      logic [31:0] r;
      walk_cmd[3] <= 1'b1;
      press_cmd[3] <= 1'b1;
      wait_ms(100);
      check(power, 4'h7);
      check(call, 4'h0);
      press_cmd[3] <= 1'b0;
      walk_cmd[3] <= 1'b0;
      wait_ms(100);
      check(power, 4'hF);
      ahb(1'b1, 32'h0, 32'h3, r);
      walk_cmd[0] <= 1'b1;
      wait_ms(100);
      check(power, 4'hE);
      wait_ms(600);
      check(power, 4'hF);
      press_cmd[0] <= 1'b1;
      wait_ms(5100);
      press_cmd[0] <= 1'b0;
      wait_ms(50);
      walk_cmd[0] <= 1'b0;
      wait_ms(100);
      check(call, 4'h1);
      wait_ms(600);
      check(call, 4'h0);
      press_cmd[0] <= 1'b1;
      wait_ms(100);
      check(call, 4'h1);
      press_cmd[0] <= 1'b0;
      wait_ms(100);
   endtask
   task automatic t_flash();
      flash_cmd[1] <= 1'b1;
      wait_ms(2100);
      check(power, 4'hD);
      flash_cmd[1] <= 1'b0;
      wait_ms(100);
      check(power, 4'hF);
   endtask
   task automatic t_override();
      logic [31:0] r;
      for (int k = 0; k < 2; k++)
      begin
         t_lock(0);
         ovr_n[k] <= 1'b0;
         wait_ms(2100);
         check(call, 4'hF);
         check(power, 4'h0);
         check(led, 4'hF);
         ahb(1'b0, 32'h4, 32'h0, r);
         check(r, 32'h0001000F);
         ovr_n <= 2'h3;
         wait_ms(100);
         check(call, 4'h0);
         check(power, 4'hF);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      n_mismatch = 0;
      num_checks = 0;
      i_resetn = 1'b0;
      i_hsel = 1'b0;
      i_haddr = 32'h0;
      i_htrans = 2'b00;
      i_hwrite = 1'b0;
      i_hwdata = 32'h0;
      ovr_n = 2'h3;
      panel = 4'h0;
      walk_cmd = 4'h0;
      flash_cmd = 4'h0;
      press_cmd = 4'h0;
      repeat (2) @(posedge i_sys_clk);
      i_resetn <= 1'b1;
      wait_ms(30);
      t_regs();
      t_panel();
      t_walk();
      t_flash();
      t_override();
      results();
   end
endmodule // testbench
